// ---- rtl/channel_counter.v ----
`timescale 1ns/1ps
`default_nettype none

module channel_counter #(
  parameter W = 16
) (
  input  wire         clock_i,
  input  wire         nrst_i,
  input  wire         ce_i,
  input  wire         tick_i,
  input  wire         run_i,
  input  wire         clear_i,
  input  wire         load_i,
  input  wire [W-1:0] load_data_i,
  input  wire [W-1:0] cmp_a_i,
  input  wire [W-1:0] cmp_b_i,
  output wire [W-1:0] count_o,
  output wire         match_a_o,
  output wire         match_b_o
);

  reg  [W-1:0] count_ff;
  reg  [W-1:0] nxt_count;
  wire         step;

  // a match only counts on an active count edge, so one match per count value
  assign step      = run_i & tick_i;
  assign match_a_o = step & (count_ff == cmp_a_i);
  assign match_b_o = step & (count_ff == cmp_b_i);
  assign count_o   = count_ff;

  // software preset beats a clear, which beats counting
  always @*
  begin
    nxt_count = count_ff;
    if (load_i)
      nxt_count = load_data_i;
    else if (clear_i)
      nxt_count = {W{1'b0}};
    else if (step)
      nxt_count = count_ff + {{(W-1){1'b0}}, 1'b1};
  end

  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      count_ff <= {W{1'b0}};
    else if (ce_i)
      count_ff <= nxt_count;
  end

endmodule
`default_nettype wire

// ---- rtl/pwm_defines.vh ----
`ifndef PWM_DEFINES_VH
`define PWM_DEFINES_VH

// register indices; the byte address on the bus is four times the index
`define IDX_RUN        16'hF030
`define IDX_SYNC       16'hF031
`define IDX_CTRL1      16'hF040
`define IDX_MODE1      16'hF041
`define IDX_PIN1       16'hF042
`define IDX_CNT1       16'hF046
`define IDX_DUTYA      16'hF048
`define IDX_DUTYB      16'hF04A
`define IDX_CTRL2      16'hF050
`define IDX_MODE2      16'hF051
`define IDX_PIN2       16'hF052
`define IDX_CNT2       16'hF056
`define IDX_DUTYC      16'hF058
`define IDX_PERIOD     16'hF05A

// reset values
`define RST_BYTE       8'h00
`define RST_CNT        16'h0000
`define RST_CMP        16'hFFFF
`define RST_BIT        1'b0

// bit positions in the run and sync registers
`define BIT_CH2        2
`define BIT_CH1        1

// count control fields
`define CCLR_HI        6
`define CCLR_LO        5
`define CKEG_HI        4
`define CKEG_LO        3
`define TPSC_HI        2
`define TPSC_LO        0
`define CCLR_NONE      2'h0
`define CCLR_CMPA      2'h1
`define CCLR_CMPB      2'h2
`define CCLR_SYNC      2'h3
`define CKEG_RISE      2'h0
`define CKEG_FALL      2'h1
`define TPSC_DIV1      3'h0
`define TPSC_DIV4      3'h1
`define TPSC_DIV16     3'h2
`define TPSC_DIV64     3'h3
`define MASK_DIV1      6'h00
`define MASK_DIV4      6'h03
`define MASK_DIV16     6'h0F
`define MASK_DIV64     6'h3F

// mode field
`define MD_HI          1
`define MD_LO          0
`define MD_PWM2        2'h3

// pin control nibbles: A in low nibble, B in high nibble
`define IOA_HI         3
`define IOA_LO         0
`define IOB_HI         7
`define IOB_LO         4
`define IO_CAPT        3
`define IO_INIT        2
`define IO_ACT_HI      1
`define IO_ACT_LO      0
`define ACT_OFF        2'h0
`define ACT_LOW        2'h1
`define ACT_HIGH       2'h2

`endif

// ---- rtl/three_phase_sync_pwm.v ----
`timescale 1ns/1ps
`default_nettype none
`include "pwm_defines.vh"

module three_phase_sync_pwm #(
  parameter CW = 16,
  parameter AW = 18
) (
  input  wire          clock_i,
  input  wire          nrst_i,
  input  wire          ce_i,
  input  wire          psel_i,
  input  wire          penable_i,
  input  wire          pwrite_i,
  input  wire [AW-1:0] paddr_i,
  input  wire [31:0]   pwdata_i,
  output reg  [31:0]   prdata_o,
  output wire          pready_o,
  output wire          pslverr_o,
  output wire          phase_a_out_o,
  output wire          phase_b_out_o,
  output wire          phase_c_out_o
);

  // software-visible registers
  reg  [1:0]    run_ff;
  reg  [1:0]    sync_ff;
  reg  [7:0]    ctrl1_ff;
  reg  [7:0]    mode1_ff;
  reg  [7:0]    pin1_ff;
  reg  [7:0]    ctrl2_ff;
  reg  [7:0]    mode2_ff;
  reg  [7:0]    pin2_ff;
  reg  [CW-1:0] duty_a_ff;
  reg  [CW-1:0] duty_b_ff;
  reg  [CW-1:0] duty_c_ff;
  reg  [CW-1:0] period_ff;

  // timing and pin state
  reg  [5:0]    presc_ff;
  reg           out_a_ff;
  reg           out_b_ff;
  reg           out_c_ff;
  reg           rd_valid_ff;

  wire [CW-1:0] cnt1;
  wire [CW-1:0] cnt2;
  wire          ma1;
  wire          mb1;
  wire          ma2;
  wire          mb2;
  wire          tick1;
  wire          tick2;
  wire          own_clr1;
  wire          own_clr2;
  wire          clr1;
  wire          clr2;
  wire          both_sync;
  wire          wr;
  wire [15:0]   idx;
  wire          hit;
  wire          wr_cnt1;
  wire          wr_cnt2;
  wire          load1;
  wire          load2;
  wire [CW-1:0] load_val;
  wire          pwm2_ch1;
  wire          pwm2_ch2;

  // count-edge generator: a masked slice of one free-running prescaler
  function tick_fn;
    input [7:0] ctrl;
    input [5:0] presc;
    reg   [5:0] mask;
    reg         ok;
    reg         rise;
    reg         fall;
    begin
      ok   = 1'b1;
      mask = `MASK_DIV1;
      case (ctrl[`TPSC_HI:`TPSC_LO])
        `TPSC_DIV1:  mask = `MASK_DIV1;
        `TPSC_DIV4:  mask = `MASK_DIV4;
        `TPSC_DIV16: mask = `MASK_DIV16;
        `TPSC_DIV64: mask = `MASK_DIV64;
        default:     ok = 1'b0;  // external sources are not wired here
      endcase
      rise = ((presc & mask) == mask);
      fall = ((presc & mask) == (mask >> 1));
      case (ctrl[`CKEG_HI:`CKEG_LO])
        `CKEG_RISE: tick_fn = ok & rise;
        `CKEG_FALL: tick_fn = ok & fall;
        default:    tick_fn = ok & (rise | fall);
      endcase
    end
  endfunction

  // clear caused by a channel's own compare match
  function own_clr_fn;
    input [7:0] ctrl;
    input       mat_a;
    input       mat_b;
    begin
      case (ctrl[`CCLR_HI:`CCLR_LO])
        `CCLR_CMPA: own_clr_fn = mat_a;
        `CCLR_CMPB: own_clr_fn = mat_b;
        default:    own_clr_fn = 1'b0;
      endcase
    end
  endfunction

  // next pin level from its control nibble
  function pin_fn;
    input       cur;
    input [3:0] io;
    input       mat;
    input       restart;
    begin
      pin_fn = cur;
      if (io[`IO_CAPT] || io[`IO_ACT_HI:`IO_ACT_LO] == `ACT_OFF)
        pin_fn = 1'b0;
      else if (restart)
        pin_fn = io[`IO_INIT];
      else if (mat)
      begin
        case (io[`IO_ACT_HI:`IO_ACT_LO])
          `ACT_LOW:  pin_fn = 1'b0;
          `ACT_HIGH: pin_fn = 1'b1;
          default:   pin_fn = ~cur;
        endcase
      end
    end
  endfunction

  // apb decode; transfers finish once read data has been captured
  assign idx       = paddr_i[AW-1:2];
  assign hit       = (paddr_i[1:0] == 2'h0) &&
                     (idx == `IDX_RUN   || idx == `IDX_SYNC  || idx == `IDX_CTRL1 ||
                      idx == `IDX_MODE1 || idx == `IDX_PIN1  || idx == `IDX_CNT1  ||
                      idx == `IDX_DUTYA || idx == `IDX_DUTYB || idx == `IDX_CTRL2 ||
                      idx == `IDX_MODE2 || idx == `IDX_PIN2  || idx == `IDX_CNT2  ||
                      idx == `IDX_DUTYC || idx == `IDX_PERIOD);
  assign pready_o  = psel_i & penable_i & rd_valid_ff & ce_i;
  assign pslverr_o = pready_o & ~hit;
  assign wr        = pready_o & pwrite_i & hit;

  // synchronous preset: a write to either counter loads both when both are locked
  assign both_sync = sync_ff[`BIT_CH2 - 1] & sync_ff[`BIT_CH1 - 1];
  assign wr_cnt1   = wr & (idx == `IDX_CNT1);
  assign wr_cnt2   = wr & (idx == `IDX_CNT2);
  assign load1     = wr_cnt1 | (both_sync & wr_cnt2);
  assign load2     = wr_cnt2 | (both_sync & wr_cnt1);
  assign load_val  = pwdata_i[CW-1:0];

  assign tick1     = tick_fn(ctrl1_ff, presc_ff);
  assign tick2     = tick_fn(ctrl2_ff, presc_ff);

  // clearing: own match, or the locked partner's own clear when source is 11
  assign own_clr1  = own_clr_fn(ctrl1_ff, ma1, mb1);
  assign own_clr2  = own_clr_fn(ctrl2_ff, ma2, mb2);
  assign clr1      = own_clr1 | (both_sync & own_clr2 &
                     (ctrl1_ff[`CCLR_HI:`CCLR_LO] == `CCLR_SYNC));
  assign clr2      = own_clr2 | (both_sync & own_clr1 &
                     (ctrl2_ff[`CCLR_HI:`CCLR_LO] == `CCLR_SYNC));

  assign pwm2_ch1  = (mode1_ff[`MD_HI:`MD_LO] == `MD_PWM2);
  assign pwm2_ch2  = (mode2_ff[`MD_HI:`MD_LO] == `MD_PWM2);

  channel_counter #(
    .W           (CW)
  ) u_ch1 (
    .clock_i     (clock_i),
    .nrst_i      (nrst_i),
    .ce_i        (ce_i),
    .tick_i      (tick1),
    .run_i       (run_ff[`BIT_CH1 - 1]),
    .clear_i     (clr1),
    .load_i      (load1),
    .load_data_i (load_val),
    .cmp_a_i     (duty_a_ff),
    .cmp_b_i     (duty_b_ff),
    .count_o     (cnt1),
    .match_a_o   (ma1),
    .match_b_o   (mb1)
  );

  channel_counter #(
    .W           (CW)
  ) u_ch2 (
    .clock_i     (clock_i),
    .nrst_i      (nrst_i),
    .ce_i        (ce_i),
    .tick_i      (tick2),
    .run_i       (run_ff[`BIT_CH2 - 1]),
    .clear_i     (clr2),
    .load_i      (load2),
    .load_data_i (load_val),
    .cmp_a_i     (duty_c_ff),
    .cmp_b_i     (period_ff),
    .count_o     (cnt2),
    .match_a_o   (ma2),
    .match_b_o   (mb2)
  );

  // register writes; a pin-control write reloads the pin's initial level
  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      run_ff    <= 2'h0;
      sync_ff   <= 2'h0;
      ctrl1_ff  <= `RST_BYTE;
      mode1_ff  <= `RST_BYTE;
      pin1_ff   <= `RST_BYTE;
      ctrl2_ff  <= `RST_BYTE;
      mode2_ff  <= `RST_BYTE;
      pin2_ff   <= `RST_BYTE;
      duty_a_ff <= `RST_CMP;
      duty_b_ff <= `RST_CMP;
      duty_c_ff <= `RST_CMP;
      period_ff <= `RST_CMP;
    end
    else if (wr)
    begin
      case (idx)
        `IDX_RUN:    run_ff    <= pwdata_i[`BIT_CH2:`BIT_CH1];
        `IDX_SYNC:   sync_ff   <= pwdata_i[`BIT_CH2:`BIT_CH1];
        `IDX_CTRL1:  ctrl1_ff  <= pwdata_i[7:0];
        `IDX_MODE1:  mode1_ff  <= pwdata_i[7:0];
        `IDX_PIN1:   pin1_ff   <= pwdata_i[7:0];
        `IDX_CTRL2:  ctrl2_ff  <= pwdata_i[7:0];
        `IDX_MODE2:  mode2_ff  <= pwdata_i[7:0];
        `IDX_PIN2:   pin2_ff   <= pwdata_i[7:0];
        `IDX_DUTYA:  duty_a_ff <= pwdata_i[CW-1:0];
        `IDX_DUTYB:  duty_b_ff <= pwdata_i[CW-1:0];
        `IDX_DUTYC:  duty_c_ff <= pwdata_i[CW-1:0];
        `IDX_PERIOD: period_ff <= pwdata_i[CW-1:0];
        default:     run_ff    <= run_ff;
      endcase
    end
  end

  // free-running prescaler shared by both channels keeps their edges aligned
  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      presc_ff <= 6'h00;
    else if (ce_i)
      presc_ff <= presc_ff + 6'h01;
  end

  // pin levels: A and B of channel 1, A of channel 2
  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      out_a_ff <= `RST_BIT;
      out_b_ff <= `RST_BIT;
      out_c_ff <= `RST_BIT;
    end
    else if (ce_i)
    begin
      if (wr && idx == `IDX_PIN1)
      begin
        out_a_ff <= pin_fn(out_a_ff, pwdata_i[`IOA_HI:`IOA_LO], 1'b0, 1'b1);
        out_b_ff <= pin_fn(out_b_ff, pwdata_i[`IOB_HI:`IOB_LO], 1'b0, 1'b1);
      end
      else
      begin
        // pin takes its nibble's match action (low, high or toggle) when the count reaches its duty value
        out_a_ff <= pin_fn(out_a_ff, pin1_ff[`IOA_HI:`IOA_LO], ma1,
                           pwm2_ch1 & clr1);
        out_b_ff <= pin_fn(out_b_ff, pin1_ff[`IOB_HI:`IOB_LO], mb1,
                           pwm2_ch1 & clr1);
      end
      if (wr && idx == `IDX_PIN2)
        out_c_ff <= pin_fn(out_c_ff, pwdata_i[`IOA_HI:`IOA_LO], 1'b0, 1'b1);
      else
        out_c_ff <= pin_fn(out_c_ff, pin2_ff[`IOA_HI:`IOA_LO], ma2,
                           pwm2_ch2 & clr2);
    end
  end

  assign phase_a_out_o = out_a_ff;
  assign phase_b_out_o = out_b_ff;
  assign phase_c_out_o = out_c_ff;

  // read data is captured before ready rises, so prdata comes from a flop
  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rd_valid_ff <= 1'b0;
      prdata_o    <= 32'h00000000;
    end
    else if (ce_i)
    begin
      rd_valid_ff <= psel_i & ~(penable_i & rd_valid_ff);
      if (psel_i && !rd_valid_ff)
      begin
        prdata_o <= 32'h00000000;
        case (hit ? idx : 16'h0000)  // refused reads, misaligned too, return zero
          `IDX_RUN:    prdata_o[`BIT_CH2:`BIT_CH1] <= run_ff;
          `IDX_SYNC:   prdata_o[`BIT_CH2:`BIT_CH1] <= sync_ff;
          `IDX_CTRL1:  prdata_o[7:0]    <= ctrl1_ff;
          `IDX_MODE1:  prdata_o[7:0]    <= mode1_ff;
          `IDX_PIN1:   prdata_o[7:0]    <= pin1_ff;
          `IDX_CNT1:   prdata_o[CW-1:0] <= cnt1;
          `IDX_DUTYA:  prdata_o[CW-1:0] <= duty_a_ff;
          `IDX_DUTYB:  prdata_o[CW-1:0] <= duty_b_ff;
          `IDX_CTRL2:  prdata_o[7:0]    <= ctrl2_ff;
          `IDX_MODE2:  prdata_o[7:0]    <= mode2_ff;
          `IDX_PIN2:   prdata_o[7:0]    <= pin2_ff;
          `IDX_CNT2:   prdata_o[CW-1:0] <= cnt2;
          `IDX_DUTYC:  prdata_o[CW-1:0] <= duty_c_ff;
          `IDX_PERIOD: prdata_o[CW-1:0] <= period_ff;
          default:     prdata_o         <= 32'h00000000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ---- tb/tb_three_phase_sync_pwm.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pwm_defines.vh"

module tb_three_phase_sync_pwm;
  logic        clock_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        ce_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [17:0] paddr_i = 18'h00000;
  logic [31:0] pwdata_i = 32'h00000000;
  wire  [31:0] prdata_o;
  wire         pready_o;
  wire         pslverr_o;
  wire         phase_a_out_o;
  wire         phase_b_out_o;
  wire         phase_c_out_o;
  int          failures = 0;
  int          n_tests = 0;
  logic [31:0] rd;
  logic        er;

  // 250 MHz system clock
  always #2 clock_i = ~clock_i;

  three_phase_sync_pwm dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .phase_a_out_o(phase_a_out_o),
    .phase_b_out_o(phase_b_out_o), .phase_c_out_o(phase_c_out_o));

  task results;
    $display("tests=%0d failures=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [17:0] ba(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction

  // one transfer; request held until ready is seen at a rising edge
  task apb(input logic w, input logic [17:0] ad, input logic [31:0] wd);
    int i;
    @(posedge clock_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= wd;
    @(posedge clock_i);
    penable_i <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clock_i);
      if (pready_o === 1'b1)
        break;
    end
    if (i == 20)
    begin
      failures++;
      results;
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task wr(input logic [15:0] idx, input logic [31:0] v);
    apb(1'b1, ba(idx), v);
  endtask

  task rdc(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, ba(idx), 32'h00000000);
    chk(rd, exp);
  endtask

  task t_reset;
    rdc(`IDX_CTRL1, 32'h00000000);
    rdc(`IDX_DUTYA, 32'h0000FFFF);
    rdc(`IDX_PERIOD, 32'h0000FFFF);
    rdc(`IDX_CNT2, 32'h00000000);
    rdc(`IDX_RUN, 32'h00000000);
  endtask

  // unmapped read, misaligned read, then a misaligned write that must be dropped
  task t_refuse;
    apb(1'b0, 18'h00004, 32'h00000000);
    chk({31'h0, er}, 32'h00000001);
    chk(rd, 32'h00000000);
    apb(1'b0, ba(`IDX_DUTYA) + 18'h00002, 32'h00000000);
    chk({31'h0, er}, 32'h00000001);
    chk(rd, 32'h00000000);
    apb(1'b1, ba(`IDX_DUTYA) + 18'h00001, 32'h00000005);
    chk({31'h0, er}, 32'h00000001);
    rdc(`IDX_DUTYA, 32'h0000FFFF);
  endtask

  // period 7, duties 1/3/5 keep the waveform short
  task t_setup;
    wr(`IDX_CTRL1, 32'h00000061);
    wr(`IDX_CTRL2, 32'h00000041);
    wr(`IDX_MODE1, 32'h00000003);
    wr(`IDX_MODE2, 32'h00000003);
    wr(`IDX_PIN1, 32'h00000022);
    wr(`IDX_PIN2, 32'h00000002);
    wr(`IDX_DUTYA, 32'h00000001);
    wr(`IDX_DUTYB, 32'h00000003);
    wr(`IDX_DUTYC, 32'h00000005);
    wr(`IDX_PERIOD, 32'h00000007);
    wr(`IDX_SYNC, 32'h00000006);
    rdc(`IDX_CTRL1, 32'h00000061);
    wr(`IDX_CNT1, 32'h00001234);
    rdc(`IDX_CNT2, 32'h00001234);
    wr(`IDX_CNT2, 32'h00000000);
    rdc(`IDX_CNT1, 32'h00000000);
    chk({29'h0, phase_a_out_o, phase_b_out_o, phase_c_out_o}, 32'h0);
    wr(`IDX_RUN, 32'h00000006);
  endtask

  // from one shared clear: low widths of each pin and the period; dv is cycles per tick
  task t_wave(input int dv);
    int k;
    int la;
    int lb;
    int lc;
    int per;
    logic pa;
    pa = 1'b0;
    for (k = 0; k < 25 * dv; k++)
    begin
      @(negedge clock_i);
      if (pa && phase_a_out_o === 1'b0)
        break;
      pa = phase_a_out_o;
    end
    // the detecting negedge is the first low cycle of every pin
    la = 1;
    lb = 1;
    lc = 1;
    per = 0;
    pa = 1'b0;
    for (k = 1; k < 15 * dv && per == 0; k++)
    begin
      @(negedge clock_i);
      if (phase_a_out_o === 1'b0 && la == k)
        la = k + 1;
      if (phase_b_out_o === 1'b0 && lb == k)
        lb = k + 1;
      if (phase_c_out_o === 1'b0 && lc == k)
        lc = k + 1;
      if (pa && phase_a_out_o === 1'b0)
        per = k;
      pa = phase_a_out_o;
    end
    // widths are (compare value + 1) ticks: duties 1, 3, 5 and period 7
    chk(la, 2 * dv);
    chk(lb, 4 * dv);
    chk(lc, 6 * dv);
    chk(per, 8 * dv);
  endtask

  // stop, preset both, run one channel only, resync, then freeze
  task t_stop;
    wr(`IDX_RUN, 32'h00000000);
    wr(`IDX_CNT1, 32'h00000003);
    repeat (20) @(posedge clock_i);
    rdc(`IDX_CNT2, 32'h00000003);
    rdc(`IDX_CNT1, 32'h00000003);
    wr(`IDX_RUN, 32'h00000002);
    repeat (40) @(posedge clock_i);
    rdc(`IDX_CNT2, 32'h00000003);
    wr(`IDX_CNT2, 32'h00000000);
    wr(`IDX_RUN, 32'h00000006);
    repeat (30) @(posedge clock_i);
    ce_i <= 1'b0;
    repeat (12) @(posedge clock_i);
    ce_i <= 1'b1;
  endtask

  // divide-by-16 on both channels stretches every width fourfold
  task t_slow;
    wr(`IDX_CTRL1, 32'h00000062);
    wr(`IDX_CTRL2, 32'h00000042);
    t_wave(16);
  endtask

  // main sequence
  initial
  begin
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_reset;
    t_refuse;
    t_setup;
    t_wave(4);
    t_stop;
    t_wave(4);
    t_slow;
    results;
  end
endmodule

`default_nettype wire

// ---- tb/three_phase_sync_pwm_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module pwm_checker #(
  parameter CW = 16,
  parameter AW = 18
) (
  input wire logic          clock_i,
  input wire logic          nrst_i,
  input wire logic          ce_i,
  input wire logic          psel_i,
  input wire logic          penable_i,
  input wire logic          pwrite_i,
  input wire logic [AW-1:0] paddr_i,
  input wire logic [31:0]   pwdata_i,
  input wire logic [31:0]   prdata_o,
  input wire logic          pready_o,
  input wire logic          pslverr_o,
  input wire logic          phase_a_out_o,
  input wire logic          phase_b_out_o,
  input wire logic          phase_c_out_o
);
  // one clock domain, so clocking and reset are set once
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  // bus answer follows the access phase only
  chk_ready_access: assert property (pready_o |-> psel_i && penable_i && ce_i)
    else $error("ready outside an enabled access");
  chk_ready_zero_wait: assert property
    ((psel_i && !penable_i && ce_i) ##1 (psel_i && penable_i && ce_i) |-> pready_o)
    else $error("ready late after enabled setup");
  chk_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  chk_err_misaligned: assert property (pready_o && paddr_i[1:0] != 2'h0 |-> pslverr_o)
    else $error("misaligned access not refused");
  chk_rdata_setup: assert property (!$stable(prdata_o) |-> $past(psel_i && !penable_i && ce_i))
    else $error("read data moved outside setup");

  // pins only move on a count tick, divide-by-four or slower in these tests, so changes sit at least four cycles apart
  chk_pin_spacing: assert property (
    !$stable({phase_a_out_o, phase_b_out_o, phase_c_out_o}) |=>
    $stable({phase_a_out_o, phase_b_out_o, phase_c_out_o})[*3])
    else $error("pin changed between count ticks");
  // a fall only comes from the shared clear, which drops every pin at once
  chk_fall_all_low: assert property (
    $fell(phase_a_out_o) || $fell(phase_b_out_o) || $fell(phase_c_out_o) |->
    !(phase_a_out_o || phase_b_out_o || phase_c_out_o))
    else $error("pins not cleared together");
  chk_hold_ce: assert property (!ce_i |=> $stable({phase_a_out_o, phase_b_out_o, phase_c_out_o}))
    else $error("pin moved while frozen");
endmodule

bind three_phase_sync_pwm pwm_checker #(.CW(CW), .AW(AW)) u_chk (
  .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .phase_a_out_o(phase_a_out_o),
  .phase_b_out_o(phase_b_out_o), .phase_c_out_o(phase_c_out_o));

`default_nettype wire
